//--- hdl/ewp_pkg.sv
// Shared constants and types for the EEPROM write-protection controller
package ewp_pkg;

   // Slave-address preambles (upper nibble)
   localparam logic [3:0] EWP_PRE_MEM    = 4'hA;
   localparam logic [3:0] EWP_PRE_PROT   = 4'h6;
   // Select bits 3..1 for the reversible-flag commands
   localparam logic [2:0] EWP_SEL_RSET   = 3'h1;
   localparam logic [2:0] EWP_SEL_RCLR   = 3'h3;
   // First byte address above the software-protected lower half
   localparam logic [7:0] EWP_LOWER_LIM  = 8'h80;
   // Bits per byte before the acknowledge slot
   localparam logic [3:0] EWP_BITS_BYTE  = 4'h8;
   // Byte index within a frame: slave address, byte address, first data byte
   localparam logic [1:0] EWP_IDX_SLAVE  = 2'h0;
   localparam logic [1:0] EWP_IDX_WADDR  = 2'h1;
   localparam logic [1:0] EWP_IDX_DATA   = 2'h2;
   // Internal nonvolatile write cycle
   localparam int         EWP_T_WR_US    = 5000;
   localparam int         EWP_CLK_MHZ    = 200;
   localparam int         EWP_WR_CYCLES  = EWP_T_WR_US * EWP_CLK_MHZ;

   typedef enum logic [2:0] {
      EWP_K_NONE,
      EWP_K_MEM_WR,
      EWP_K_MEM_RD,
      EWP_K_QUERY,
      EWP_K_SET_PERM,
      EWP_K_SET_REV,
      EWP_K_CLR_REV
   } ewp_kind_e;

   typedef struct packed {
      logic scl;
      logic sda;
      logic a2;
      logic a1;
      logic a0;
      logic ovd;
      logic wp;
   } ewp_pins_s;

   typedef struct packed {
      logic permanent_protect_flag;
      logic reversible_protect_flag;
   } ewp_flags_s;

   typedef struct packed {
      logic       valid;
      logic [7:0] addr;
      logic [7:0] data;
   } ewp_mem_byte_s;

   typedef struct packed {
      logic      ack;
      ewp_kind_e kind;
   } ewp_dec_s;

endpackage

//--- hdl/ewp_ctrl.sv
// Two-wire slave front end with software and hardware write protection
// Functional notes
// - Either flag blocks writes to bytes 0-127
// - Permanent flag commands work without overvoltage
// - Reversible commands honoured only with overvoltage present
// - Preamble 0110 selects protection, 1010 memory
// - Permanent: select bits match pins; reversible: fixed
// - Overvoltage on input 0 reads as one
// - Address LSB one queries, zero sets/clears
// - Query answers NACK if flag set, else ACK
// - Write-protect high blocks memory and flag writes
// - Write-protect low has no effect
// - Write-protect sampled on falling edge before data
// - Sampled high: NACK data, no write cycle
// - Reversible set 001 pins 00, clear 011 pins 01
// - Permanent set NACKs all protection commands; reversible set NACKs set
// - STOP after accepted write launches write cycle
// - No address ACK while write cycle runs
`timescale 1ns/10ps
`default_nettype none
module ewp_ctrl #(
   parameter int WR_CYCLES = ewp_pkg::EWP_WR_CYCLES
) (
   input  wire  logic                   clk_sys,
   input  wire  logic                   rstn,
   input  wire  logic                   scl_pin,
   input  wire  logic                   sda_pin_in,
   output logic                         sda_pin_out,
   output logic                         sda_pin_oe_n,
   input  wire  logic                   addr_select_bit0,
   input  wire  logic                   addr_select_bit1,
   input  wire  logic                   addr_select_bit2,
   input  wire  logic                   overvoltage_detect,
   input  wire  logic                   wp_pin,
   input  wire  ewp_pkg::ewp_flags_s    nv_flags_init,
   output ewp_pkg::ewp_flags_s          soft_protect_flags,
   output logic                         write_busy,
   output ewp_pkg::ewp_mem_byte_s       mem_byte,
   output logic                         mem_commit
);
   import ewp_pkg::*;

   localparam int CW = $clog2(WR_CYCLES + 1);

   // The write-cycle counter needs at least one cycle to count down
   if (WR_CYCLES < 1) begin : g_cfg_chk
      $error("WR_CYCLES must be at least one");
   end

   typedef enum logic [1:0] {
      EWP_ST_IDLE,
      EWP_ST_RECV,
      EWP_ST_ACK,
      EWP_ST_IGNORE
   } ewp_state_e;

   ////////////////////////////////////////////////////////////////////////////
   // Pin synchronisers and bus condition detection

   ewp_pins_s     pins_raw;
   ewp_pins_s     pin_m_q;
   ewp_pins_s     pin_s_q;
   logic          scl_d_q;
   logic          sda_d_q;
   logic          scl_rise;
   logic          scl_fall;
   logic          start_cond;
   logic          stop_cond;
   logic          a0_eff;

   assign pins_raw = '{scl: scl_pin, sda: sda_pin_in, a2: addr_select_bit2,
                       a1: addr_select_bit1, a0: addr_select_bit0,
                       ovd: overvoltage_detect, wp: wp_pin};

   // Idle levels at reset so no false START is seen on release
   always_ff @(posedge clk_sys) begin
      if (!rstn) begin
         pin_m_q <= '{scl: 1'b1, sda: 1'b1, default: 1'b0};
         pin_s_q <= '{scl: 1'b1, sda: 1'b1, default: 1'b0};
         scl_d_q <= 1'b1;
         sda_d_q <= 1'b1;
      end else begin
         pin_m_q <= pins_raw;
         pin_s_q <= pin_m_q;
         scl_d_q <= pin_s_q.scl;
         sda_d_q <= pin_s_q.sda;
      end
   end

   assign scl_rise   = pin_s_q.scl & ~scl_d_q;
   assign scl_fall   = ~pin_s_q.scl & scl_d_q;
   assign start_cond = pin_s_q.scl & scl_d_q & sda_d_q & ~pin_s_q.sda;
   assign stop_cond  = pin_s_q.scl & scl_d_q & ~sda_d_q & pin_s_q.sda;
   // Overvoltage counts as a logic one on select input 0
   assign a0_eff     = pin_s_q.a0 | pin_s_q.ovd;

   ////////////////////////////////////////////////////////////////////////////
   // Slave-address decode

   function automatic ewp_dec_s decode_addr(input logic [7:0] b,
                                            input ewp_pins_s p,
                                            input logic a0e,
                                            input ewp_flags_s f,
                                            input logic busy);
      ewp_dec_s r;
      r.ack  = 1'b0;
      r.kind = EWP_K_NONE;
      if (busy) begin
         r.ack = 1'b0;
      end else if (b[7:4] == EWP_PRE_MEM) begin
         if (b[3:1] == {p.a2, p.a1, a0e}) begin
            r.ack  = 1'b1;
            r.kind = b[0] ? EWP_K_MEM_RD : EWP_K_MEM_WR;
         end
      end else if (b[7:4] == EWP_PRE_PROT) begin
         if (!p.ovd) begin
            // Permanent flag: select bits follow the pins as they sit
            if (b[3:1] == {p.a2, p.a1, p.a0}) begin
               r.ack  = !f.permanent_protect_flag;
               r.kind = b[0] ? EWP_K_QUERY : EWP_K_SET_PERM;
            end
         end else if (b[3:1] == EWP_SEL_RSET && !p.a2 && !p.a1) begin
            r.ack  = !f.permanent_protect_flag && !f.reversible_protect_flag;
            r.kind = b[0] ? EWP_K_QUERY : EWP_K_SET_REV;
         end else if (b[3:1] == EWP_SEL_RCLR && !p.a2 && p.a1) begin
            r.ack  = !f.permanent_protect_flag;
            r.kind = b[0] ? EWP_K_QUERY : EWP_K_CLR_REV;
         end
      end
      return r;
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // Serial state machine

   ewp_state_e    state_q;
   logic [3:0]    bit_cnt_q;
   logic [7:0]    shift_q;
   logic [1:0]    byte_idx_q;
   ewp_kind_e     kind_q;
   logic          acked_q;
   logic          wp_smp_q;
   logic          reject_q;
   logic          data_seen_q;
   logic [7:0]    waddr_q;
   logic          sda_oe_n_q;
   ewp_mem_byte_s mem_byte_q;
   ewp_flags_s    flags_q;
   logic          busy_q;
   logic          data_ok;
   ewp_dec_s      dec;

   assign dec = decode_addr(shift_q, pin_s_q, a0_eff, flags_q, busy_q);

   // Data byte acceptance; protection checks use the sampled write-protect
   always_comb begin
      data_ok = !wp_smp_q;
      if (kind_q == EWP_K_MEM_WR && waddr_q < EWP_LOWER_LIM &&
          (flags_q.permanent_protect_flag || flags_q.reversible_protect_flag)) begin
         data_ok = 1'b0;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!rstn) begin
         state_q     <= EWP_ST_IDLE;
         bit_cnt_q   <= 4'h0;
         shift_q     <= 8'h00;
         byte_idx_q  <= EWP_IDX_SLAVE;
         kind_q      <= EWP_K_NONE;
         acked_q     <= 1'b0;
         wp_smp_q    <= 1'b0;
         reject_q    <= 1'b0;
         data_seen_q <= 1'b0;
         waddr_q     <= 8'h00;
         sda_oe_n_q  <= 1'b1;
      end else if (start_cond) begin
         state_q     <= EWP_ST_RECV;
         bit_cnt_q   <= 4'h0;
         byte_idx_q  <= EWP_IDX_SLAVE;
         kind_q      <= EWP_K_NONE;
         reject_q    <= 1'b0;
         data_seen_q <= 1'b0;
         sda_oe_n_q  <= 1'b1;
      end else if (stop_cond) begin
         state_q    <= EWP_ST_IDLE;
         sda_oe_n_q <= 1'b1;
      end else begin
         case (state_q)
            EWP_ST_RECV: begin
               if (scl_rise && bit_cnt_q < EWP_BITS_BYTE) begin
                  shift_q   <= {shift_q[6:0], pin_s_q.sda};
                  bit_cnt_q <= bit_cnt_q + 4'h1;
               end else if (scl_fall && bit_cnt_q == EWP_BITS_BYTE) begin
                  state_q <= EWP_ST_ACK;
                  if (byte_idx_q == EWP_IDX_SLAVE) begin
                     kind_q     <= dec.kind;
                     acked_q    <= dec.ack;
                     sda_oe_n_q <= !dec.ack;
                  end else if (byte_idx_q == EWP_IDX_WADDR) begin
                     acked_q    <= 1'b1;
                     sda_oe_n_q <= 1'b0;
                     waddr_q    <= shift_q;
                  end else begin
                     acked_q    <= data_ok;
                     sda_oe_n_q <= !data_ok;
                     if (data_ok) begin
                        data_seen_q <= 1'b1;
                     end else begin
                        reject_q <= 1'b1;
                     end
                  end
               end
            end
            EWP_ST_ACK: begin
               if (scl_fall) begin
                  sda_oe_n_q <= 1'b1;
                  bit_cnt_q  <= 4'h0;
                  // Last falling edge before the first data byte
                  if (byte_idx_q == EWP_IDX_WADDR) begin
                     wp_smp_q <= pin_s_q.wp;
                  end
                  // Steps only after a data byte, so the first byte lands at the sent address
                  if (byte_idx_q == EWP_IDX_DATA) begin
                     waddr_q <= {waddr_q[7:4], waddr_q[3:0] + 4'h1};
                  end
                  // Queries and reads carry no data from this block
                  if (!acked_q || kind_q == EWP_K_QUERY || kind_q == EWP_K_MEM_RD) begin
                     state_q <= EWP_ST_IGNORE;
                  end else begin
                     state_q <= EWP_ST_RECV;
                     if (byte_idx_q != EWP_IDX_DATA) begin
                        byte_idx_q <= byte_idx_q + 2'h1;
                     end
                  end
               end
            end
            EWP_ST_IGNORE: begin
               sda_oe_n_q <= 1'b1;
            end
            default: begin
               state_q    <= EWP_ST_IDLE;
               sda_oe_n_q <= 1'b1;
            end
         endcase
      end
   end

   // Accepted memory bytes go to the core page buffer as they arrive
   always_ff @(posedge clk_sys) begin
      if (!rstn) begin
         mem_byte_q <= '0;
      end else begin
         mem_byte_q.valid <= 1'b0;
         if (!start_cond && !stop_cond && state_q == EWP_ST_RECV && scl_fall &&
             bit_cnt_q == EWP_BITS_BYTE && byte_idx_q == EWP_IDX_DATA &&
             kind_q == EWP_K_MEM_WR && data_ok) begin
            mem_byte_q.valid <= 1'b1;
            mem_byte_q.addr  <= waddr_q;
            mem_byte_q.data  <= shift_q;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Write cycle and nonvolatile flags

   logic [CW-1:0] wr_cnt_q;
   logic          init_done_q;
   logic          commit_q;
   logic          launch;

   // A rejected byte discards the whole request; a bare address never commits
   assign launch = stop_cond && state_q != EWP_ST_IDLE && !reject_q && data_seen_q &&
                   kind_q inside {EWP_K_MEM_WR, EWP_K_SET_PERM, EWP_K_SET_REV,
                                  EWP_K_CLR_REV};

   always_ff @(posedge clk_sys) begin
      if (!rstn) begin
         wr_cnt_q <= '0;
         busy_q   <= 1'b0;
         commit_q <= 1'b0;
      end else begin
         commit_q <= launch && kind_q == EWP_K_MEM_WR;
         if (launch) begin
            busy_q   <= 1'b1;
            wr_cnt_q <= CW'(WR_CYCLES - 1);
         end else if (busy_q) begin
            if (wr_cnt_q == '0) begin
               busy_q <= 1'b0;
            end else begin
               wr_cnt_q <= wr_cnt_q - CW'(1);
            end
         end
      end
   end

   // Stored flag image is reloaded from the core once after reset
   always_ff @(posedge clk_sys) begin
      if (!rstn) begin
         flags_q     <= '0;
         init_done_q <= 1'b0;
      end else if (!init_done_q) begin
         flags_q     <= nv_flags_init;
         init_done_q <= 1'b1;
      end else if (launch) begin
         case (kind_q)
            EWP_K_SET_PERM: flags_q.permanent_protect_flag  <= 1'b1;
            EWP_K_SET_REV:  flags_q.reversible_protect_flag <= 1'b1;
            EWP_K_CLR_REV:  flags_q.reversible_protect_flag <= 1'b0;
            default:        flags_q                         <= flags_q;
         endcase
      end
   end

   assign sda_pin_out        = 1'b0;
   assign sda_pin_oe_n       = sda_oe_n_q;
   assign soft_protect_flags = flags_q;
   assign write_busy         = busy_q;
   assign mem_byte           = mem_byte_q;
   assign mem_commit         = commit_q;

endmodule
`default_nettype wire

//--- bench/ewp_ctrl_sva.sv
// Port-level assertions for the write-protection controller
`timescale 1ns/10ps
`default_nettype none
module ewp_ctrl_sva #(
   parameter int WR_CYCLES = ewp_pkg::EWP_WR_CYCLES
) (
   input wire logic                   clk_sys,
   input wire logic                   rstn,
   input wire logic                   wp_pin,
   input wire logic                   sda_pin_out,
   input wire logic                   sda_pin_oe_n,
   input wire ewp_pkg::ewp_flags_s    soft_protect_flags,
   input wire logic                   write_busy,
   input wire ewp_pkg::ewp_mem_byte_s mem_byte,
   input wire logic                   mem_commit
);
   import ewp_pkg::*;
   logic [31:0] busy_cnt_q;
   logic [1:0]  up_q;
   logic        perm;
   logic        low_hit;
   assign perm = soft_protect_flags.permanent_protect_flag;
   assign low_hit = mem_byte.valid && (mem_byte.addr < EWP_LOWER_LIM);
   always_ff @(posedge clk_sys) begin
      busy_cnt_q <= write_busy ? busy_cnt_q + 32'h1 : 32'h0;
   end
   // Masks the one flag change that comes from the stored image after reset
   always_ff @(posedge clk_sys) begin
      up_q <= rstn ? {up_q[0], 1'b1} : 2'h0;
   end
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!rstn);
   ////////////////////////////////////////
   chk_commit_busy: assert property (mem_commit |-> ##[0:2] write_busy)
      else $error("commit without write cycle");
   chk_busy_len: assert property ($fell(write_busy) |-> busy_cnt_q == WR_CYCLES)
      else $error("write cycle length wrong");
   chk_busy_nack: assert property (write_busy |-> sda_pin_oe_n)
      else $error("acknowledge during write cycle");
   chk_perm_sticky: assert property ($past(perm) |-> perm)
      else $error("permanent flag cleared");
   chk_flag_launch: assert property (up_q[1] && !$stable(soft_protect_flags) |-> ##[0:1] write_busy)
      else $error("flag changed outside write cycle");
   chk_wp_block: assert property ($rose(write_busy) |-> !$past(wp_pin, 8))
      else $error("write cycle while write protect high");
   chk_lower_half: assert property (low_hit |-> soft_protect_flags == 2'h0)
      else $error("lower half byte accepted while protected");
   chk_valid_acked: assert property (mem_byte.valid |-> !sda_pin_oe_n)
      else $error("data byte passed without acknowledge");
   chk_ack_holds: assert property ($fell(sda_pin_oe_n) |-> !sda_pin_oe_n [*8])
      else $error("acknowledge released early");
   chk_drive_low: assert property (!sda_pin_oe_n |-> !sda_pin_out)
      else $error("data line driven high");
endmodule
bind ewp_ctrl ewp_ctrl_sva #(.WR_CYCLES(WR_CYCLES)) chk_u (
   .clk_sys(clk_sys), .rstn(rstn), .wp_pin(wp_pin), .sda_pin_out(sda_pin_out),
   .sda_pin_oe_n(sda_pin_oe_n), .soft_protect_flags(soft_protect_flags),
   .write_busy(write_busy), .mem_byte(mem_byte), .mem_commit(mem_commit));
`default_nettype wire

//--- bench/ewp_master_model.sv
// Two-wire bus master model for the serial clock and data lines
`timescale 1ns/10ps
`default_nettype none
module ewp_master_model (
   input  wire logic sda_w,
   output logic      scl,
   output logic      sda_m
);
   event got;
   logic ackv;
   // Clock idles high between frames and never runs free
   initial begin
      scl = 1'b1;
      sda_m = 1'b1;
   end
   ////////////////////////////////////////
   // 48 ns per bit; data moves only while the clock is low
   task automatic bit_io(input logic b, output logic r);
      sda_m = b;
      #12 scl = 1'b1;
      #12 r = sda_w;
      #12 scl = 1'b0;
      #12;
   endtask
   task automatic start_c;
      sda_m = 1'b0;
      #24 scl = 1'b0;
      #24;
   endtask
   task automatic stop_c;
      sda_m = 1'b0;
      #24 scl = 1'b1;
      #24 sda_m = 1'b1;
      #24;
   endtask
   task automatic tx(input logic [7:0] d);
      logic r;
      for (int i = 7; i >= 0; i--) begin
         bit_io(d[i], r);
      end
      bit_io(1'b1, r);
      ackv = ~r;
      ->got;
   endtask
endmodule
`default_nettype wire

//--- bench/eeprom_write_protect_ctrl_test.sv
// Self-checking bench for the write-protection controller
`timescale 1ns/10ps
`default_nettype none
module eeprom_write_protect_ctrl_test;
   import ewp_pkg::*;
   logic          clk_sys, rstn, scl, sda_m, sda_w;
   logic          overvoltage_detect, wp_pin, sda_pin_out, sda_pin_oe_n;
   logic          write_busy, mem_commit;
   logic [2:0]    sel_pins;
   ewp_flags_s    soft_protect_flags, nv_init;
   ewp_mem_byte_s mem_byte, mem_q[$];
   logic          exp_q[$];
   int            fail_count, comparisons, cyc, commit_seen, commit_exp;
   integer        seed = 4464;
   // Open-drain wire with pull-up; an unknown enable counts as released
   assign sda_w = sda_m & ~(sda_pin_oe_n === 1'b0 && sda_pin_out === 1'b0);
   ewp_ctrl #(.WR_CYCLES(200)) dut_u (
      .clk_sys(clk_sys), .rstn(rstn), .scl_pin(scl), .sda_pin_in(sda_w),
      .sda_pin_out(sda_pin_out), .sda_pin_oe_n(sda_pin_oe_n),
      .addr_select_bit0(sel_pins[0]), .addr_select_bit1(sel_pins[1]),
      .addr_select_bit2(sel_pins[2]), .overvoltage_detect(overvoltage_detect),
      .wp_pin(wp_pin), .nv_flags_init(nv_init), .soft_protect_flags(soft_protect_flags),
      .write_busy(write_busy), .mem_byte(mem_byte), .mem_commit(mem_commit));
   ewp_master_model mst_u (.sda_w(sda_w), .scl(scl), .sda_m(sda_m));
   always #2.5 clk_sys = ~clk_sys;
   ////////////////////////////////////////
   task automatic tally_and_finish;
      if (fail_count == 0 && comparisons > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask
   task automatic chk_ack(input logic a);
      logic e;
      comparisons++;
      e = exp_q.size() ? exp_q.pop_front() : 1'bx;
      if (a !== e) begin
         fail_count++;
         $display("mismatch %0t ack got %b exp %b", $time, a, e);
      end
   endtask
   task automatic chk_flags(input logic [1:0] e);
      comparisons++;
      if (soft_protect_flags !== e) begin
         fail_count++;
         $display("mismatch %0t flags got %b exp %b", $time, soft_protect_flags, e);
      end
   endtask
   // Done mode: every noted byte seen and commit pulses match the count
   task automatic chk_mem(input logic done);
      ewp_mem_byte_s e;
      comparisons++;
      if (done) begin
         if (mem_q.size() != 0 || commit_seen != commit_exp) begin
            fail_count++;
            $display("mismatch %0t mem left %0d commits %0d exp %0d", $time,
                     mem_q.size(), commit_seen, commit_exp);
            mem_q.delete();
            commit_seen = commit_exp;
         end
      end else begin
         e = mem_q.size() ? mem_q.pop_front() : '0;
         if (mem_byte !== e) begin
            fail_count++;
            $display("mismatch %0t mem byte got %h exp %h", $time, mem_byte, e);
         end
      end
   endtask
   always @(mst_u.got) chk_ack(mst_u.ackv);
   // Pulses are looked at half a cycle after launch, while they stand
   always @(negedge clk_sys) begin
      if (mem_byte.valid === 1'b1) chk_mem(1'b0);
      if (mem_commit === 1'b1) commit_seen++;
   end
   always @(posedge clk_sys) begin
      cyc++;
      if (cyc == 30000) begin
         fail_count++;
         tally_and_finish();
      end
   end
   // A refused byte ends the frame, as the master would on a not-acknowledge
   task automatic frame(input logic [7:0] s, b, input int n, input logic [2:0] e);
      logic [7:0] d;
      logic       mw;
      mw = (s[7:4] == EWP_PRE_MEM) && !s[0];
      mst_u.start_c();
      for (int i = 0; i < n; i++) begin
         d = (i == 0) ? s : (i == 1) ? b : 8'($random(seed));
         exp_q.push_back(e[i]);
         if (mw && i >= 2 && e[i]) begin
            mem_q.push_back('{valid: 1'b1, addr: {b[7:4], b[3:0] + 4'(i - 2)}, data: d});
         end
         mst_u.tx(d);
         if (!e[i]) break;
      end
      if (mw && n == 3 && e == 3'h7) begin
         commit_exp++;
      end
      mst_u.stop_c();
   endtask
   // Pins are set before START and held past STOP; f[2] skips the settle
   task automatic step(input logic [4:0] p, input logic [7:0] s, b, input int n,
                       input logic [2:0] e, f);
      int k;
      @(negedge clk_sys);
      {overvoltage_detect, wp_pin, sel_pins} = p;
      repeat (4) @(negedge clk_sys);
      frame(s, b, n, e);
      if (!f[2]) begin
         k = 0;
         repeat (8) @(negedge clk_sys);
         while (write_busy !== 1'b0 && k < 400) begin
            @(negedge clk_sys);
            k++;
         end
         if (k == 400) begin
            fail_count++;
            $display("mismatch %0t write cycle did not end", $time);
         end
         chk_flags(f[1:0]);
         chk_mem(1'b1);
      end
   endtask
   initial begin
      clk_sys = 1'b0;
      rstn = 1'b0;
      overvoltage_detect = 1'b0;
      wp_pin = 1'b0;
      sel_pins = 3'h0;
      nv_init = 2'h0;
      repeat (10) @(negedge clk_sys);
      rstn = 1'b1;
      step(5'h05, 8'h6B, 8'h00, 1, 3'h1, 3'h0);
      step(5'h11, 8'h63, 8'h00, 1, 3'h1, 3'h0);
      step(5'h05, 8'hAA, 8'h05, 3, 3'h7, 3'h0);
      step(5'h04, 8'h6B, 8'h00, 1, 3'h0, 3'h0);
      step(5'h05, 8'h5A, 8'h00, 1, 3'h0, 3'h0);
      step(5'h19, 8'h62, 8'h33, 3, 3'h3, 3'h0);
      step(5'h11, 8'h62, 8'h44, 3, 3'h7, 3'h4);
      step(5'h11, 8'hA3, 8'h00, 1, 3'h0, 3'h1);
      step(5'h11, 8'h63, 8'h00, 1, 3'h0, 3'h1);
      step(5'h11, 8'h62, 8'h00, 3, 3'h0, 3'h1);
      step(5'h05, 8'hAA, 8'h10, 3, 3'h3, 3'h1);
      step(5'h05, 8'hAA, 8'h90, 3, 3'h7, 3'h1);
      step(5'h13, 8'h66, 8'h00, 3, 3'h7, 3'h0);
      step(5'h13, 8'h67, 8'h00, 1, 3'h1, 3'h0);
      step(5'h05, 8'h6A, 8'h00, 3, 3'h7, 3'h2);
      step(5'h05, 8'h6B, 8'h00, 1, 3'h0, 3'h2);
      step(5'h13, 8'h66, 8'h00, 1, 3'h0, 3'h2);
      step(5'h05, 8'hAA, 8'h20, 3, 3'h3, 3'h2);
      step(5'h0D, 8'hAA, 8'h90, 3, 3'h3, 3'h2);
      step(5'h10, 8'hA3, 8'h00, 1, 3'h1, 3'h2);
      // Mid-run reset: the stored image must come back as written
      nv_init = 2'h2;
      @(negedge clk_sys);
      rstn = 1'b0;
      repeat (3) @(negedge clk_sys);
      chk_flags(2'h0);
      rstn = 1'b1;
      repeat (2) @(negedge clk_sys);
      chk_flags(2'h2);
      step(5'h05, 8'h6B, 8'h00, 1, 3'h0, 3'h2);
      tally_and_finish();
   end
endmodule
`default_nettype wire
